// File: core/rxcr_consts.vh
`ifndef RXCR_CONSTS_VH
`define RXCR_CONSTS_VH
// register addresses
`define RXCR_ADDR_RCV 8'h38
`define RXCR_ADDR_ANA 8'h39
`define RXCR_ADDR_BAUD 8'h3b
`define RXCR_ADDR_LFO 8'h3c
`define RXCR_ADDR_SYN 8'h3d
`define RXCR_ADDR_ODIV 8'h3e
// writable bit masks
`define RXCR_MASK_RCV 8'hf3
`define RXCR_MASK_ANA 8'hcf
`define RXCR_MASK_FULL 8'hff
// reset values
`define RXCR_RST_RCV 8'h00
`define RXCR_RST_ANA 8'h00
`define RXCR_RST_BAUD 8'h7a
`define RXCR_RST_LFO 8'h00
`define RXCR_RST_SYN 8'h00
`define RXCR_RST_ODIV 8'h08
// field positions
`define RXCR_RCV_SINGLE 7
`define RXCR_RCV_ADC 6
`define RXCR_ANA_HPCF_LSB 2
`define RXCR_SYN_EN 3
`define RXCR_SYN_PD 2
// feedback ratios
`define RXCR_FB_RATIO_0 5'h17
`define RXCR_FB_RATIO_1 5'h1b
`define RXCR_FB_RATIO_2 5'h1c
// serial baud formula constants, full period width
`define RXCR_BAUD_ADD_LO 16'h0001
`define RXCR_BAUD_ADD_HI 16'h0021
// serial character length: start, eight data, stop
`define RXCR_FRAME_BITS 4'ha
`endif

// File: core/rxcr_regs.v
`timescale 1ns/1ps
`include "rxcr_consts.vh"
module rxcr_regs (
	// clock and reset
	input wire clk,
	input wire rst_b,
	input wire ce,
	// register port, same clock domain
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	output reg [7:0] reg_rdata_ff,
	output reg reg_hit_ff,
	// receive front end controls
	output reg rx_single_ff,
	output reg rx_low_power_card_detect_mode_ff,
	output reg [1:0] signal_source_select_ff,
	output reg [1:0] collision_threshold_ff,
	output reg collision_detect_en_ff,
	output reg [1:0] midrail_trim_ff,
	output reg [1:0] rcv_hpcf_ff,
	output reg [1:0] rcv_gain_ff,
	// serial host port timing
	output reg [15:0] baud_period_ff,
	output reg [3:0] frame_bits_ff,
	// clocking controls
	output reg [7:0] slow_osc_trim_value_ff,
	output reg [3:0] clock_pin_source_ff,
	output reg clock_pin_enable_ff,
	output reg synth_powerdown_ff,
	output reg [4:0] synth_fb_ratio_ff,
	output reg [7:0] synth_output_divider_ff,
	output reg [12:0] synth_mult_ff,
	output reg [1:0] clock_pin_mode_ff,
	output reg [1:0] clock_pin_arg_ff
);
	// 8N1: start + 8 data + stop, no parity
	localparam [3:0] FRAME_BITS = `RXCR_FRAME_BITS;
	reg [7:0] rcv_ff;
	reg [7:0] ana_ff;
	reg [7:0] baud_ff;
	reg [7:0] syn_ff;
	reg [7:0] nxt_rdata;
	reg nxt_hit;
	reg [15:0] nxt_period;
	reg [4:0] nxt_ratio;
	reg [1:0] nxt_pin_mode;
	wire [2:0] baud_exp;
	wire [4:0] baud_man;
	wire [15:0] baud_man_ext;

	// keeps bits outside the mask, so reserved bits stay at zero
	function [7:0] wmask;
		input [7:0] cur;
		input [7:0] wd;
		input [7:0] msk;
		begin
			wmask = (cur & ~msk) | (wd & msk);
		end
	endfunction

	assign baud_exp = baud_ff[7:5];
	assign baud_man = baud_ff[4:0];
	assign baud_man_ext = {11'h000, baud_man};

	// ce low freezes both the registers and the derived outputs
	// register writes; reserved bits are masked off
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rcv_ff <= `RXCR_RST_RCV;
			ana_ff <= `RXCR_RST_ANA;
			baud_ff <= `RXCR_RST_BAUD;
			slow_osc_trim_value_ff <= `RXCR_RST_LFO;
			syn_ff <= `RXCR_RST_SYN;
			synth_output_divider_ff <= `RXCR_RST_ODIV;
		end else if (ce && reg_wr) begin
			case (reg_addr)
			`RXCR_ADDR_RCV: begin
				rcv_ff <= wmask(rcv_ff, reg_wdata, `RXCR_MASK_RCV);
			end
			`RXCR_ADDR_ANA: begin
				ana_ff <= wmask(ana_ff, reg_wdata, `RXCR_MASK_ANA);
			end
			`RXCR_ADDR_BAUD: begin
				baud_ff <= reg_wdata;
			end
			`RXCR_ADDR_LFO: begin
				slow_osc_trim_value_ff <= reg_wdata;
			end
			`RXCR_ADDR_SYN: begin
				syn_ff <= reg_wdata;
			end
			`RXCR_ADDR_ODIV: begin
				// values below 8 are stored as written; software avoids them
				synth_output_divider_ff <= reg_wdata;
			end
			default: begin
			end
			endcase
		end
	end

	// read mux
	always @* begin
		nxt_hit = 1'b1;
		case (reg_addr)
		`RXCR_ADDR_RCV: nxt_rdata = rcv_ff;
		`RXCR_ADDR_ANA: nxt_rdata = ana_ff;
		`RXCR_ADDR_BAUD: nxt_rdata = baud_ff;
		`RXCR_ADDR_LFO: nxt_rdata = slow_osc_trim_value_ff;
		`RXCR_ADDR_SYN: nxt_rdata = syn_ff;
		`RXCR_ADDR_ODIV: nxt_rdata = synth_output_divider_ff;
		default: begin
			nxt_rdata = 8'h00;
			nxt_hit = 1'b0;
		end
		endcase
	end

	// bit period in crystal cycles
	// widen first: mantissa 31 plus 33 no longer fits six bits
	always @* begin
		if (baud_exp == 3'h0) begin
			nxt_period = baud_man_ext + `RXCR_BAUD_ADD_LO;
		end else begin
			nxt_period = (baud_man_ext + `RXCR_BAUD_ADD_HI)
				<< (baud_exp - 3'h1);
		end
	end

	// codes 0 and 3 share the lowest ratio
	always @* begin
		case (syn_ff[1:0])
		2'b01: nxt_ratio = `RXCR_FB_RATIO_1;
		2'b10: nxt_ratio = `RXCR_FB_RATIO_2;
		default: nxt_ratio = `RXCR_FB_RATIO_0;
		endcase
	end

	// pin source in groups of four: direct, crystal divide, timer, reserved
	always @* begin
		case (syn_ff[7:4])
		4'h0, 4'h1, 4'h2, 4'h3: nxt_pin_mode = 2'h0;
		4'h4, 4'h5, 4'h6, 4'h7: nxt_pin_mode = 2'h1;
		4'h8, 4'h9, 4'ha, 4'hb: nxt_pin_mode = 2'h2;
		default: nxt_pin_mode = 2'h3;
		endcase
	end

	// derived outputs are registered so every output comes from a flop
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata_ff <= 8'h00;
			reg_hit_ff <= 1'b0;
			rx_single_ff <= 1'b0;
			rx_low_power_card_detect_mode_ff <= 1'b0;
			signal_source_select_ff <= 2'h0;
			collision_threshold_ff <= 2'h0;
			collision_detect_en_ff <= 1'b1;
			midrail_trim_ff <= 2'h0;
			rcv_hpcf_ff <= 2'h0;
			rcv_gain_ff <= 2'h0;
			baud_period_ff <= 16'h0000;
			frame_bits_ff <= FRAME_BITS;
			clock_pin_source_ff <= 4'h0;
			clock_pin_enable_ff <= 1'b0;
			synth_powerdown_ff <= 1'b0;
			synth_fb_ratio_ff <= `RXCR_FB_RATIO_0;
			synth_mult_ff <= 13'h0000;
			clock_pin_mode_ff <= 2'h0;
			clock_pin_arg_ff <= 2'h0;
		end else if (ce) begin
			// read data and hit hold until the next read strobe
			if (reg_rd) begin
				reg_rdata_ff <= nxt_rdata;
				reg_hit_ff <= nxt_hit;
			end
			rx_single_ff <= rcv_ff[`RXCR_RCV_SINGLE];
			rx_low_power_card_detect_mode_ff <= rcv_ff[`RXCR_RCV_ADC];
			signal_source_select_ff <= rcv_ff[5:4];
			collision_threshold_ff <= rcv_ff[1:0];
			collision_detect_en_ff <= (rcv_ff[1:0] != 2'h3);
			// stored as written; a nonzero trim is a software fault
			midrail_trim_ff <= ana_ff[7:6];
			rcv_hpcf_ff <= ana_ff[`RXCR_ANA_HPCF_LSB +: 2];
			rcv_gain_ff <= ana_ff[1:0];
			baud_period_ff <= nxt_period;
			frame_bits_ff <= FRAME_BITS;
			clock_pin_source_ff <= syn_ff[7:4];
			clock_pin_enable_ff <= syn_ff[`RXCR_SYN_EN];
			synth_powerdown_ff <= syn_ff[`RXCR_SYN_PD];
			synth_fb_ratio_ff <= nxt_ratio;
			// product of feedback ratio and output divider; no crystal or /2 term
			synth_mult_ff <= {8'h00, nxt_ratio} * {5'h00,
				synth_output_divider_ff};
			// mode 0 static/io/synth, 1 crystal div, 2 timer toggle, 3 reserved
			clock_pin_mode_ff <= nxt_pin_mode;
			clock_pin_arg_ff <= syn_ff[5:4];
		end
	end
endmodule

// File: sim/rxcr_regs_props.sv
`timescale 1ns/1ps
module rxcr_regs_props (
	// clock and reset
	input wire clk,
	input wire rst_b,
	// register port
	input wire ce,
	input wire [7:0] reg_addr,
	input wire reg_wr,
	input wire reg_rd,
	input wire [7:0] reg_wdata,
	input wire [7:0] reg_rdata_ff,
	input wire reg_hit_ff,
	// derived controls
	input wire collision_detect_en_ff,
	input wire [15:0] baud_period_ff,
	input wire [3:0] frame_bits_ff,
	input wire [4:0] synth_fb_ratio_ff
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	wire rd_take = ce && reg_rd;
	wire wr_go = ce && reg_wr;
	wire [2:0] ex = reg_wdata[7:5];
	wire [15:0] man = {11'h0, reg_wdata[4:0]};
	wire [15:0] baud_exp = ex == 3'h0 ? man + 16'h1 :
		(man + 16'h21) << (ex - 3'h1);
	wire [4:0] fb_exp = reg_wdata[1:0] == 2'h1 ? 5'h1b :
		(reg_wdata[1:0] == 2'h2 ? 5'h1c : 5'h17);
	wire mapped = reg_addr >= 8'h38 && reg_addr <= 8'h3e && reg_addr != 8'h3a;
	// derived fields may lag the register by one edge, so look two edges on
	chk_frame_fixed:
	assert property (frame_bits_ff == 4'ha) else $error("bad frame length");
	chk_collision_enable:
	assert property (wr_go && reg_addr == 8'h38 |-> ##2 collision_detect_en_ff
		== ($past(reg_wdata[1:0], 2) != 2'h3))
		else $error("bad collision enable");
	chk_feedback_ratio:
	assert property (wr_go && reg_addr == 8'h3d |-> ##2
		synth_fb_ratio_ff == $past(fb_exp, 2)) else $error("bad feedback ratio");
	chk_baud_direct:
	assert property (wr_go && reg_addr == 8'h3b && ex == 3'h0 |-> ##2
		baud_period_ff == $past(baud_exp, 2)) else $error("bad direct period");
	chk_baud_scaled:
	assert property (wr_go && reg_addr == 8'h3b && ex != 3'h0 |-> ##2
		baud_period_ff == $past(baud_exp, 2)) else $error("bad scaled period");
	chk_read_hit:
	assert property (rd_take |=> reg_hit_ff == $past(mapped))
		else $error("bad hit");
	chk_rcv_reserved:
	assert property (rd_take && reg_addr == 8'h38 |=> reg_rdata_ff[3:2] == 2'h0)
		else $error("rcv reserved bits set");
	chk_ana_reserved:
	assert property (rd_take && reg_addr == 8'h39 |=> reg_rdata_ff[5:4] == 2'h0)
		else $error("ana reserved bits set");
endmodule
bind rxcr_regs rxcr_regs_props i_props (.clk, .rst_b, .ce, .reg_addr, .reg_wr,
	.reg_rd, .reg_wdata, .reg_rdata_ff, .reg_hit_ff, .collision_detect_en_ff,
	.baud_period_ff, .frame_bits_ff, .synth_fb_ratio_ff);

// File: sim/rxcr_regs_tb.sv
`timescale 1ns/1ps
module rxcr_regs_tb;
	reg clk = 1'b0;
	reg rst_b = 1'b0;
	reg ce = 1'b1;
	reg reg_wr = 1'b0;
	reg reg_rd = 1'b0;
	reg [7:0] reg_addr = 8'h00;
	reg [7:0] reg_wdata = 8'h00;
	wire [7:0] reg_rdata_ff;
	wire reg_hit_ff, collision_detect_en_ff;
	wire [15:0] baud_period_ff;
	wire [4:0] synth_fb_ratio_ff;
	int err_count = 0;
	int total_checks = 0;
	int i;
	logic [7:0] rv [7] = '{8'h00, 8'h00, 8'h00, 8'h7a, 8'h00, 8'h00, 8'h08};
	logic [7:0] bc [7] = '{8'heb, 8'h15, 8'h7a, 8'hfa, 8'h1c, 8'h1f, 8'h3f};
	logic [4:0] fv [4] = '{5'h17, 5'h1b, 5'h1c, 5'h17};
	wire sgl, low_power_card_detect, cken, pdn;
	wire [1:0] src, thr, mid, hpcf, gain, cpm, cpa;
	wire [3:0] fbits, cps;
	wire [7:0] trim, odiv;
	wire [12:0] mult;
	rxcr_regs i_dut (.clk, .rst_b, .ce, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
		.reg_rdata_ff, .reg_hit_ff, .rx_single_ff(sgl), .rx_low_power_card_detect_mode_ff(low_power_card_detect),
		.signal_source_select_ff(src), .collision_threshold_ff(thr),
		.collision_detect_en_ff, .midrail_trim_ff(mid), .rcv_hpcf_ff(hpcf),
		.rcv_gain_ff(gain), .baud_period_ff, .frame_bits_ff(fbits),
		.slow_osc_trim_value_ff(trim), .clock_pin_source_ff(cps),
		.clock_pin_enable_ff(cken), .synth_powerdown_ff(pdn), .synth_fb_ratio_ff,
		.synth_output_divider_ff(odiv), .synth_mult_ff(mult),
		.clock_pin_mode_ff(cpm), .clock_pin_arg_ff(cpa));
	always #20 clk = ~clk;
	function [15:0] period(input [7:0] c);
		period = c[7:5] == 3'h0 ? 16'(c[4:0]) + 16'h1 :
			(16'(c[4:0]) + 16'h21) << (c[7:5] - 3'h1);
	endfunction
	task chk(input string n, input [15:0] e, input [15:0] g);
		total_checks++;
		if (g !== e) begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask
	// waits past the derived outputs, which settle up to two edges late
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (3) @(negedge clk);
	endtask
	task rd(input [7:0] a, input [7:0] e, input h);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(negedge clk);
		chk("rdata", 16'(e), 16'(reg_rdata_ff));
		chk("hit", 16'(h), 16'(reg_hit_ff));
	endtask
	task final_report;
		$display("checks %0d mismatches %0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge clk);
		rst_b <= 1'b1;
		for (i = 0; i < 7; i++)
			rd(8'h38 + 8'(i), rv[i], i != 2);
		chk("period", 16'hec, baud_period_ff);
		chk("frame", 16'ha, 16'(fbits));
		wr(8'h38, 8'hb6);
		rd(8'h38, 8'hb2, 1'b1);
		chk("rcv_fields", 16'h2e, 16'({sgl, low_power_card_detect, src, thr}));
		wr(8'h39, 8'h1b);
		rd(8'h39, 8'h0b, 1'b1);
		chk("ana_fields", 16'h0b, 16'({mid, hpcf, gain}));
		wr(8'h3a, 8'h55);
		rd(8'h3a, 8'h00, 1'b0);
		wr(8'h3c, 8'ha5);
		rd(8'h3c, 8'ha5, 1'b1);
		chk("trim", 16'ha5, 16'(trim));
		for (i = 0; i < 4; i++) begin
			wr(8'h38, 8'(i));
			chk("coll_en", 16'(i != 3), 16'(collision_detect_en_ff));
			wr(8'h3d, 8'h50 | 8'(i));
			chk("fb_ratio", 16'(fv[i]), 16'(synth_fb_ratio_ff));
		end
		rd(8'h3d, 8'h53, 1'b1);
		wr(8'h3d, 8'hac);
		chk("syn_fields", 16'h2b, 16'({cps, cken, pdn}));
		chk("pin_mode", 16'ha, 16'({cpm, cpa}));
		wr(8'h3e, 8'h10);
		rd(8'h3e, 8'h10, 1'b1);
		chk("out_div", 16'h10, 16'(odiv));
		chk("synth_mult", 16'h170, 16'(mult));
		for (i = 0; i < 7; i++) begin
			wr(8'h3b, bc[i]);
			chk("period", period(bc[i]), baud_period_ff);
		end
		final_report;
	end
endmodule
